// ===== bench/avr_frame_responder_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// port-level checks of the core domain
module avr_frame_responder_monitor
    import avr_pkg::*;
#(
    parameter int CHANNELS = 2
)(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // watched pins
    input wire logic sdata_oe_out,
    input wire logic vdone_in,
    input wire logic pmbus_clear_fault_in,
    input wire logic [15:0] warn_set_in,
    input wire logic [15:0] vout_min_in,
    input wire logic [15:0] vout_max_in,
    input wire logic [CHANNELS-1:0][15:0] vout_target_out,
    input wire logic [15:0] avs_warning_status_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    // pin drive, status layout, latching and clearing
    a_pin_always_driven: assert property (sdata_oe_out) else $error("pin undriven");
    a_reserved_bits_zero: assert property ((avs_warning_status_out & 16'h0f01) == 16'h0000)
        else $error("reserved set");
    a_done_bit_live: assert property (avs_warning_status_out[15] == vdone_in) else $error("done bit");
    a_warn_set_latch: assert property ((warn_set_in & STATUS_LATCH_MASK) != 16'h0000 |=>
        (avs_warning_status_out & $past(warn_set_in) & STATUS_LATCH_MASK) == ($past(warn_set_in) & STATUS_LATCH_MASK))
        else $error("warning lost");
    a_no_spurious_set: assert property ((avs_warning_status_out & ~$past(avs_warning_status_out)
        & ~$past(warn_set_in) & STATUS_LATCH_MASK) == 16'h0000) else $error("spurious warning");
    a_mgmt_clear_narrow: assert property (pmbus_clear_fault_in && avs_warning_status_out[14]
        |=> avs_warning_status_out[14]) else $error("mgmt clear leaked");
    // a limit change would make a moving target look wrong; limits stay fixed after reset
    a_clamp_ch_a: assert property (!$stable(vout_target_out[0]) |-> vout_target_out[0] >= vout_min_in
        && vout_target_out[0] <= vout_max_in) else $error("target a out of window");
    a_clamp_ch_b: assert property (!$stable(vout_target_out[1]) |-> vout_target_out[1] >= vout_min_in
        && vout_target_out[1] <= vout_max_in) else $error("target b out of window");
endmodule

bind avr_frame_responder avr_frame_responder_monitor #(.CHANNELS(CHANNELS)) mon (.*);

`default_nettype wire

// ===== bench/avr_frame_responder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module avr_frame_responder_tb_top
    import avr_pkg::*;
;
    // design pins, named as the ports
    logic clock_in = 0, rst_in = 1, latch_off_in = 0, conv_enabled_in = 1, busy_in = 0, vdone_in = 0;
    logic link_owns_output_in = 0, reset_pin_low_flag_in = 0, pmbus_clear_fault_in = 0;
    logic [15:0] warn_set_in = 0, vout_min_in = 16'h0100, vout_max_in = 16'h0800, avs_warning_status_out, v;
    logic [1:0][15:0] pmbus_vout_in, pmbus_slew_in, boot_voltage_in, current_in, temp_in, vout_target_out;
    logic [1:0][7:0] slew_rise_out, slew_fall_out;
    wire logic link_clk_in, mdata_in, sdata_out, sdata_oe_out;
    logic [15:0] st = 0, tv [3];
    logic [31:0] r, m, rm [6], re [6];
    int error_cnt = 0, samples_checked = 0, seed = 32'hb9cc120b;

    ////////////////////////////////////////////////////////////////////////////////
    // clock, design and host
    initial forever #5 clock_in = ~clock_in;
    avr_frame_responder dut (.*);
    avr_host_model host (.link_clk_out(link_clk_in), .mdata_out(mdata_in), .sdata_in(sdata_out));

    ////////////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [2:0] crc(input logic [28:0] d);
        logic [2:0] c = 3'h0;
        for (int i = 28; i >= 0; i--) c = {c[1], c[0] ^ d[i] ^ c[2], d[i] ^ c[2]};
        return c;
    endfunction
    function automatic logic [31:0] mf(input logic [1:0] a, input logic [4:0] t, input logic [3:0] s,
        input logic [15:0] d);
        return {START_PATTERN, a, t, s, d, crc({START_PATTERN, a, t, s, d})};
    endfunction
    // reply as built from the live state inputs and the modelled warnings
    function automatic logic [31:0] rf(input logic [1:0] k, input logic [15:0] d);
        logic [28:0] h;
        h = {k, 1'b0, vdone_in, |st, link_owns_output_in, reset_pin_low_flag_in, 1'b0, d, 5'h1f};
        return {h, crc(h)};
    endfunction
    function automatic logic [15:0] cl(input logic [15:0] x);
        return (x < vout_min_in) ? vout_min_in : (x > vout_max_in) ? vout_max_in : x;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // a frame's reply arrives during the following version read
    task automatic tr(input logic [31:0] f, output logic [31:0] rep);
        host.xfer(f, rep);
        host.xfer(mf(ACC_READ, 5'h0f, SEL_ALL, READ_FILL), rep);
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        for (int c = 0; c < 2; c++) begin
            pmbus_vout_in[c] = 16'h0200 + 16'(c);
            pmbus_slew_in[c] = 16'h0a02;
            boot_voltage_in[c] = 16'h0370 + 16'(c);
            current_in[c] = 16'($random(seed));
            temp_in[c] = 16'($random(seed));
        end
        // link side resets only while its clock runs
        fork host.spin(6); repeat (10) @(posedge clock_in); join
        @(posedge clock_in) rst_in <= 1'b0;
        // three more pulses lift the link reset exactly at the first frame's first rising edge
        host.spin(3);
        chk(vout_target_out, pmbus_vout_in);
        @(posedge clock_in) {vdone_in, link_owns_output_in, reset_pin_low_flag_in} <= 3'($random(seed));
        tv = '{16'($random(seed)) | 16'h1000, 16'h0010, 16'h0320};
        foreach (tv[i]) begin
            tr(mf(ACC_COMMIT, 5'h00, SEL_CH_A, tv[i]), r);
            chk(r, rf(ACK_OK, 16'hffff));
            chk(vout_target_out[0], cl(tv[i]));
            tr(mf(ACC_READ, 5'h00, SEL_CH_A, READ_FILL), r);
            chk(r, rf(ACK_OK, cl(tv[i])));
        end
        tr(mf(ACC_HOLD, 5'h00, SEL_CH_B, 16'h0400), r);
        chk(vout_target_out[1], pmbus_vout_in[1]);
        v = 16'($random(seed));
        tr(mf(ACC_COMMIT, 5'h01, SEL_CH_B, v), r);
        chk(vout_target_out[1], 16'h0400);
        chk({slew_rise_out[1], slew_fall_out[1]}, v);
        // broadcast is refused for voltage reset, so park channel a and commit channel b
        tr(mf(ACC_HOLD, 5'h04, SEL_CH_A, 16'h0000), r);
        tr(mf(ACC_COMMIT, 5'h04, SEL_CH_B, 16'h0000), r);
        chk(vout_target_out, boot_voltage_in);
        for (int c = 0; c < 2; c++) begin
            tr(mf(ACC_READ, 5'h02, 4'(c), READ_FILL), r);
            chk(r, rf(ACK_OK, current_in[c]));
            tr(mf(ACC_READ, 5'h03, 4'(c), READ_FILL), r);
            chk(r, rf(ACK_OK, temp_in[c]));
        end
        tr(mf(ACC_COMMIT, 5'h05, SEL_CH_A, 16'h0123), r);
        chk(r, rf(ACK_OK, 16'hffff));
        $display("writes and reads done");
        // refused frames: bad crc, maker group, broadcast voltage, bad start, busy, latch-off
        m = mf(ACC_COMMIT, 5'h00, SEL_CH_A, 16'h0300);
        rm = '{m ^ 32'h1, mf(ACC_COMMIT, 5'h10, SEL_CH_A, 16'h0300), mf(ACC_COMMIT, 5'h00, SEL_ALL, 16'h0300),
            m ^ 32'hc000_0000, m, m};
        re = '{rf(ACK_BAD_CRC, 16'hffff), rf(ACK_INVALID, 16'hffff), rf(ACK_INVALID, 16'hffff), '1,
            rf(ACK_BUSY, 16'hffff), '1};
        for (int i = 0; i < 6; i++) begin
            @(posedge clock_in) {busy_in, latch_off_in} <= {i == 4, i == 5};
            tr(rm[i], r);
            chk(r, re[i]);
        end
        @(posedge clock_in) latch_off_in <= 1'b0;
        chk(vout_target_out, boot_voltage_in);
        $display("refusals done");
        // bit 0 is reserved and must not latch; management clear comes first
        @(posedge clock_in) warn_set_in <= 16'h4011;
        @(posedge clock_in) warn_set_in <= 16'h0000;
        st = 16'h4010;
        @(posedge clock_in) pmbus_clear_fault_in <= 1'b1;
        @(posedge clock_in) pmbus_clear_fault_in <= 1'b0;
        tr(mf(ACC_READ, 5'h0e, SEL_CH_A, READ_FILL), r);
        chk(r, rf(ACK_OK, {vdone_in, 15'h4010}));
        chk(sdata_out, 1'b0);
        tr(mf(ACC_HOLD, 5'h0e, SEL_CH_B, 16'h4010), r);
        st = 16'h0000;
        tr(mf(ACC_READ, 5'h0e, SEL_ALL, READ_FILL), r);
        chk(r, rf(ACK_OK, {vdone_in, 15'h0000}));
        chk(sdata_out, 1'b1);
        $display("warnings done");
        give_verdict();
    end

    // hang guard
    initial begin
        #600000;
        error_cnt++;
        give_verdict();
    end
endmodule

`default_nettype wire

// ===== bench/avr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the link; the clock stands still between frames
module avr_host_model (
    // link pins
    output logic link_clk_out,
    output logic mdata_out,
    input wire logic sdata_in
);
    // clock idles low, data line idles high
    initial begin
        link_clk_out = 1'b0;
        mdata_out = 1'b1;
    end

    // clock pulses with no frame, used only to walk the link side through reset
    task automatic spin(input int n);
        repeat (n) begin
            #80 link_clk_out = 1'b1;
            #80 link_clk_out = 1'b0;
        end
    endtask

    // one frame: launch on rising, sample on falling, msb first
    task automatic xfer(input logic [31:0] m, output logic [31:0] rep);
        for (int i = 31; i >= 0; i--) begin
            #80 link_clk_out = 1'b1;
            mdata_out = m[i];
            #80 rep[i] = sdata_in;
            link_clk_out = 1'b0;
        end
        #80 mdata_out = 1'b1;
        // the gap gives the core time to build the next reply
        #200;
    endtask
endmodule

`default_nettype wire

// ===== design/avr_frame_responder.sv
`timescale 1ns/1ps
`default_nettype none

module avr_frame_responder
    import avr_pkg::*;
#(
    parameter int CHANNELS = 2
)(
    // core clock and reset
    input wire logic clock_in,
    input wire logic rst_in,
    // link pins
    input wire logic link_clk_in,
    input wire logic mdata_in,
    output logic sdata_out,
    output logic sdata_oe_out,
    // power-stage state
    input wire logic latch_off_in,
    input wire logic conv_enabled_in,
    input wire logic busy_in,
    input wire logic vdone_in,
    input wire logic link_owns_output_in,
    input wire logic reset_pin_low_flag_in,
    // warning events and management-side clear
    input wire logic [15:0] warn_set_in,
    input wire logic pmbus_clear_fault_in,
    // limits, start values and telemetry per channel
    input wire logic [15:0] vout_min_in,
    input wire logic [15:0] vout_max_in,
    input wire logic [CHANNELS-1:0][15:0] pmbus_vout_in,
    input wire logic [CHANNELS-1:0][15:0] pmbus_slew_in,
    input wire logic [CHANNELS-1:0][15:0] boot_voltage_in,
    input wire logic [CHANNELS-1:0][15:0] current_in,
    input wire logic [CHANNELS-1:0][15:0] temp_in,
    // applied targets and status
    output logic [CHANNELS-1:0][15:0] vout_target_out,
    output logic [CHANNELS-1:0][7:0] slew_rise_out,
    output logic [CHANNELS-1:0][7:0] slew_fall_out,
    output logic [15:0] avs_warning_status_out
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [31:0] rx_word, tx_word_r, tx_word_nxt;
    logic rx_tgl, rx_tgl_s, rx_tgl_d_r, tx_tgl_r, tx_tgl_nxt, new_frame;
    logic init_r;
    logic [CHANNELS-1:0][15:0] vout_r, vout_nxt, slew_r, slew_nxt;
    logic [CHANNELS-1:0][15:0] vout_pend_r, vout_pend_nxt, slew_pend_r, slew_pend_nxt;
    logic [CHANNELS-1:0] vout_pv_r, vout_pv_nxt, slew_pv_r, slew_pv_nxt, vrst_pv_r, vrst_pv_nxt;
    logic [15:0] warn_r, warn_nxt, status_view;
    logic ph_pm_r, ph_pm_nxt, ph_avs_r, ph_avs_nxt, alert_r, alert_nxt;
    logic start_ok, crc_ok, group_ok, sel_ok, acc_ok, cmd_known, is_read, is_write, is_commit;
    logic [1:0] acc;
    logic [3:0] sel;
    logic [15:0] payload, rd_data;
    logic [CHANNELS-1:0] ch_mask;
    avr_cmd_e cmd;
    avr_ack_e ack;
    logic [4:0] summary;
    logic accept, respond;

    // clamp a voltage target into the configured window
    function automatic logic [15:0] clamp_v(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link side and crossing of the frame toggle
    avr_link u_link (
        .link_clk_in(link_clk_in),
        .rst_in(rst_in),
        .mdata_in(mdata_in),
        .sdata_out(sdata_out),
        .sdata_oe_out(sdata_oe_out),
        .alert_in(alert_r),
        .tx_word_in(tx_word_r),
        .tx_tgl_in(tx_tgl_r),
        .rx_word_out(rx_word),
        .rx_tgl_out(rx_tgl)
    );

    avr_sync u_rx_sync (
        .clk_in(clock_in),
        .rst_in(rst_in),
        .d_in(rx_tgl),
        .q_out(rx_tgl_s)
    );

    assign new_frame = rx_tgl_s ^ rx_tgl_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // frame decode
    always_comb begin
        acc = rx_word[29:28];
        sel = rx_word[22:19];
        payload = rx_word[18:3];
        cmd = avr_cmd_e'(rx_word[26:23]);
        start_ok = (rx_word[31:30] == START_PATTERN);
        crc_ok = (avr_crc3(rx_word[31:3]) == rx_word[2:0]);
        group_ok = ~rx_word[27];
        is_read = (acc == ACC_READ);
        is_commit = (acc == ACC_COMMIT);
        is_write = is_commit || (acc == ACC_HOLD);
        // known commands and the accesses each allows
        cmd_known = 1'b1;
        acc_ok = 1'b0;
        unique case (rx_word[26:23])
            CMD_VOUT, CMD_SLEW, CMD_STATUS, CMD_POWER_MODE: acc_ok = is_read || is_write;
            CMD_CURRENT, CMD_TEMP, CMD_VERSION: acc_ok = is_read;
            CMD_VRESET: acc_ok = is_write;
            default: cmd_known = 1'b0;
        endcase
        // broadcast only for status and version
        ch_mask = '0;
        sel_ok = 1'b1;
        if (sel == SEL_CH_A) begin
            ch_mask[0] = 1'b1;
        end else if (sel == SEL_CH_B) begin
            ch_mask[1] = 1'b1;
        end else if (sel == SEL_ALL && (cmd == CMD_STATUS || cmd == CMD_VERSION)) begin
            ch_mask = '1;
        end else begin
            sel_ok = 1'b0;
        end
        // acknowledge priority: crc, then busy, then validity
        if (!crc_ok) begin
            ack = ACK_BAD_CRC;
        end else if (busy_in) begin
            ack = ACK_BUSY;
        end else if (!(group_ok && cmd_known && acc_ok && sel_ok)) begin
            ack = ACK_INVALID;
        end else begin
            ack = ACK_OK;
        end
        // silent while latched off or not converting
        respond = new_frame && init_r && start_ok && conv_enabled_in && !latch_off_in;
        accept = respond && (ack == ACK_OK);
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and reply word
    always_comb begin
        status_view = warn_r & STATUS_LATCH_MASK; // reserved and unsupported bits read zero
        status_view[STATUS_VDONE_BIT] = vdone_in;
        rd_data = READ_FILL; // writes answer with ones
        if (is_read) begin
            unique case (rx_word[26:23])
                CMD_VOUT: rd_data = vout_r[sel[0]]; // stored target, not measured
                CMD_SLEW: rd_data = slew_r[sel[0]];
                CMD_CURRENT: rd_data = current_in[sel[0]]; // 10 mA per step
                CMD_TEMP: rd_data = temp_in[sel[0]]; // signed tenths of a degree
                CMD_STATUS: rd_data = status_view;
                CMD_VERSION: rd_data = VERSION_VALUE;
                CMD_POWER_MODE: rd_data = POWER_MODE_VALUE;
                default: rd_data = READ_FILL;
            endcase
        end
        // done, any warning, owner, reset pin, zero
        summary = {vdone_in, |(warn_r & STATUS_LATCH_MASK), link_owns_output_in, reset_pin_low_flag_in, 1'b0};
        tx_word_nxt = tx_word_r;
        tx_tgl_nxt = tx_tgl_r;
        if (respond) begin
            tx_word_nxt[31:3] = {ack, RESP_RSVD_HI, summary, rd_data, RESP_RSVD_LO};
            tx_word_nxt[2:0] = avr_crc3(tx_word_nxt[31:3]);
            tx_tgl_nxt = ~tx_tgl_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // targets: hold writes park a value, commit writes apply all parked values
    always_comb begin
        vout_nxt = vout_r;
        slew_nxt = slew_r;
        vout_pend_nxt = vout_pend_r;
        slew_pend_nxt = slew_pend_r;
        vout_pv_nxt = vout_pv_r;
        slew_pv_nxt = slew_pv_r;
        vrst_pv_nxt = vrst_pv_r;
        if (!init_r) begin
            for (int i = 0; i < CHANNELS; i++) begin
                vout_nxt[i] = clamp_v(pmbus_vout_in[i], vout_min_in, vout_max_in);
                slew_nxt[i] = pmbus_slew_in[i];
            end
        end else if (accept && is_write) begin
            // an earlier hold is applied first, so the commit's own value wins
            if (is_commit) begin
                for (int i = 0; i < CHANNELS; i++) begin
                    if (vrst_pv_r[i]) begin
                        vout_nxt[i] = boot_voltage_in[i];
                    end
                    if (vout_pv_r[i]) begin
                        vout_nxt[i] = vout_pend_r[i];
                    end
                    if (slew_pv_r[i]) begin
                        slew_nxt[i] = slew_pend_r[i];
                    end
                end
                vout_pv_nxt = '0;
                slew_pv_nxt = '0;
                vrst_pv_nxt = '0;
            end
            for (int i = 0; i < CHANNELS; i++) begin
                if (ch_mask[i]) begin
                    if (cmd == CMD_VOUT && is_commit) begin
                        vout_nxt[i] = clamp_v(payload, vout_min_in, vout_max_in);
                    end else if (cmd == CMD_VOUT) begin
                        vout_pend_nxt[i] = clamp_v(payload, vout_min_in, vout_max_in);
                        vout_pv_nxt[i] = 1'b1;
                        vrst_pv_nxt[i] = 1'b0;
                    end else if (cmd == CMD_SLEW && is_commit) begin
                        slew_nxt[i] = payload;
                    end else if (cmd == CMD_SLEW) begin
                        slew_pend_nxt[i] = payload;
                        slew_pv_nxt[i] = 1'b1;
                    end else if (cmd == CMD_VRESET && is_commit) begin
                        vout_nxt[i] = boot_voltage_in[i];
                    end else if (cmd == CMD_VRESET) begin
                        vrst_pv_nxt[i] = 1'b1;
                        vout_pv_nxt[i] = 1'b0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // warning register: a new event wins over a clear in the same cycle
    always_comb begin
        logic [15:0] clr;
        logic [15:0] setv;
        clr = '0;
        setv = warn_set_in & STATUS_LATCH_MASK;
        ph_pm_nxt = ph_pm_r | pmbus_clear_fault_in; // management clears touch only bit 4 here
        ph_avs_nxt = ph_avs_r;
        // any status write clears the ones it carries, power mode does nothing
        if (accept && is_write && cmd == CMD_STATUS) begin
            clr = payload & STATUS_LATCH_MASK;
            ph_avs_nxt = ph_avs_r | payload[STATUS_PHASE_BIT];
        end
        clr[STATUS_PHASE_BIT] = 1'b0;
        // the per-phase bit drops only after both kinds of clear
        if (ph_pm_nxt && ph_avs_nxt) begin
            clr[STATUS_PHASE_BIT] = 1'b1;
            ph_pm_nxt = 1'b0;
            ph_avs_nxt = 1'b0;
        end
        warn_nxt = ((warn_r & ~clr) | setv) & STATUS_LATCH_MASK;
        alert_nxt = |warn_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers of the core domain
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rx_tgl_d_r <= 1'b0;
            init_r <= 1'b0;
            tx_word_r <= '1;
            tx_tgl_r <= 1'b0;
            vout_r <= '0;
            slew_r <= '0;
            vout_pend_r <= '0;
            slew_pend_r <= '0;
            vout_pv_r <= '0;
            slew_pv_r <= '0;
            vrst_pv_r <= '0;
            warn_r <= STATUS_RESET;
            ph_pm_r <= 1'b0;
            ph_avs_r <= 1'b0;
            alert_r <= 1'b0;
        end else begin
            rx_tgl_d_r <= rx_tgl_s;
            init_r <= 1'b1;
            tx_word_r <= tx_word_nxt;
            tx_tgl_r <= tx_tgl_nxt;
            vout_r <= vout_nxt;
            slew_r <= slew_nxt;
            vout_pend_r <= vout_pend_nxt;
            slew_pend_r <= slew_pend_nxt;
            vout_pv_r <= vout_pv_nxt;
            slew_pv_r <= slew_pv_nxt;
            vrst_pv_r <= vrst_pv_nxt;
            warn_r <= warn_nxt;
            ph_pm_r <= ph_pm_nxt;
            ph_avs_r <= ph_avs_nxt;
            alert_r <= alert_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs: rising rate in the upper byte, falling in the lower
    generate
        for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
            assign vout_target_out[g] = vout_r[g];
            assign slew_rise_out[g] = slew_r[g][15:8];
            assign slew_fall_out[g] = slew_r[g][7:0];
        end
    endgenerate

    assign avs_warning_status_out = status_view;

endmodule

`default_nettype wire

// ===== design/avr_link.sv
`timescale 1ns/1ps
`default_nettype none

// link-clock side: shifts master frames in on falling edges, replies on rising edges
module avr_link
    import avr_pkg::*;
(
    // link clock and core reset level
    input wire logic link_clk_in,
    input wire logic rst_in,
    // serial pins
    input wire logic mdata_in,
    output logic sdata_out,
    output logic sdata_oe_out,
    // core side
    input wire logic alert_in,
    input wire logic [31:0] tx_word_in,
    input wire logic tx_tgl_in,
    output logic [31:0] rx_word_out,
    output logic rx_tgl_out
);

    logic lrst;
    logic [31:0] rx_sh_r, rx_sh_nxt, rx_word_r, rx_word_nxt, tx_sh_r, tx_sh_nxt;
    logic [4:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
    logic rx_tgl_r, rx_tgl_nxt, tx_act_r, tx_act_nxt, tx_seen_r, tx_seen_nxt;

    // reset reaches this domain only while the link clock runs
    avr_sync u_rst_sync (
        .clk_in(link_clk_in),
        .rst_in(1'b0),
        .d_in(rst_in),
        .q_out(lrst)
    );

    ////////////////////////////////////////////////////////////////////////////
    // receive: sample on the falling edge, msb first
    always_comb begin
        rx_sh_nxt = {rx_sh_r[30:0], mdata_in};
        rx_cnt_nxt = rx_cnt_r + 5'h1;
        rx_word_nxt = rx_word_r;
        rx_tgl_nxt = rx_tgl_r;
        if (rx_cnt_r == LAST_BIT_IDX) begin
            rx_word_nxt = rx_sh_nxt; // word held stable before the toggle is seen
            rx_tgl_nxt = ~rx_tgl_r;
        end
    end

    always_ff @(negedge link_clk_in) begin
        if (lrst) begin
            rx_sh_r <= '0;
            rx_cnt_r <= '0;
            rx_word_r <= '0;
            rx_tgl_r <= 1'b0;
        end else begin
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_word_r <= rx_word_nxt;
            rx_tgl_r <= rx_tgl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit: launch on the rising edge; a reply is taken at a frame's first bit.
    // the core finishes within half a link period, so the word is settled by then.
    always_comb begin
        tx_sh_nxt = {tx_sh_r[30:0], 1'b1};
        tx_cnt_nxt = tx_cnt_r + 5'h1;
        tx_act_nxt = tx_act_r;
        tx_seen_nxt = tx_seen_r;
        if (rx_cnt_r == 5'h0) begin
            tx_act_nxt = (tx_tgl_in != tx_seen_r);
            tx_seen_nxt = tx_tgl_in;
            tx_sh_nxt = tx_word_in;
            tx_cnt_nxt = 5'h0;
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (lrst) begin
            tx_sh_r <= '1;
            tx_cnt_r <= LAST_BIT_IDX;
            tx_act_r <= 1'b0;
            tx_seen_r <= 1'b0;
        end else begin
            tx_sh_r <= tx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_act_r <= tx_act_nxt;
            tx_seen_r <= tx_seen_nxt;
        end
    end

    // idle high; a pending warning pulls the line low between replies
    always_comb begin
        if (tx_act_r && !(tx_cnt_r == LAST_BIT_IDX && rx_cnt_r == 5'h0)) begin
            sdata_out = tx_sh_r[31];
        end else begin
            sdata_out = ~alert_in;
        end
    end

    assign sdata_oe_out = 1'b1;
    assign rx_word_out = rx_word_r;
    assign rx_tgl_out = rx_tgl_r;

endmodule

`default_nettype wire

// ===== design/avr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// three-stage synchroniser; the output follows once stages two and three agree
module avr_sync (
    // clock and reset of the receiving domain
    input wire logic clk_in,
    input wire logic rst_in,
    // asynchronous level in, settled level out
    input wire logic d_in,
    output logic q_out
);

    logic s1_r, s2_r, s3_r, q_r;
    logic q_nxt;

    // settle only when the last two stages agree
    always_comb begin
        q_nxt = (s2_r == s3_r) ? s3_r : q_r;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            s1_r <= d_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;

endmodule

`default_nettype wire

// ===== shared/avr_pkg.sv
package avr_pkg;

    // frame geometry
    localparam int FRAME_BITS = 32;
    localparam int CRC_SPAN = 29;
    localparam logic [4:0] LAST_BIT_IDX = 5'h1f;

    // master frame field values
    localparam logic [1:0] START_PATTERN = 2'h1;
    localparam logic [1:0] ACC_READ = 2'h3;
    localparam logic [1:0] ACC_HOLD = 2'h1;
    localparam logic [1:0] ACC_COMMIT = 2'h0;
    localparam logic [3:0] SEL_CH_A = 4'h0;
    localparam logic [3:0] SEL_CH_B = 4'h1;
    localparam logic [3:0] SEL_ALL = 4'hf;
    localparam logic [15:0] READ_FILL = 16'hffff;

    // command types
    typedef enum logic [3:0] {
        CMD_VOUT = 4'h0,
        CMD_SLEW = 4'h1,
        CMD_CURRENT = 4'h2,
        CMD_TEMP = 4'h3,
        CMD_VRESET = 4'h4,
        CMD_POWER_MODE = 4'h5,
        CMD_STATUS = 4'he,
        CMD_VERSION = 4'hf
    } avr_cmd_e;

    // acknowledge codes
    typedef enum logic [1:0] {
        ACK_OK = 2'h0,
        ACK_BUSY = 2'h1,
        ACK_BAD_CRC = 2'h2,
        ACK_INVALID = 2'h3
    } avr_ack_e;

    // response constant fields
    localparam logic RESP_RSVD_HI = 1'b0;
    localparam logic [4:0] RESP_RSVD_LO = 5'h1f;

    // warning status register layout and reset values
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] STATUS_LATCH_MASK = 16'h70fe;
    localparam int STATUS_VDONE_BIT = 15;
    localparam int STATUS_PHASE_BIT = 4;
    localparam logic [15:0] VERSION_VALUE = 16'h0000;
    localparam logic [15:0] POWER_MODE_VALUE = 16'h0000;
    localparam logic [15:0] TARGET_RESET = 16'h0000;

    // crc over a frame's leading bits, x^3 + x + 1, msb first, zero seed
    function automatic logic [2:0] avr_crc3(input logic [CRC_SPAN-1:0] d);
        logic [2:0] c;
        logic fb;
        c = 3'h0;
        for (int i = CRC_SPAN - 1; i >= 0; i--) begin
            fb = d[i] ^ c[2];
            c = {c[1], c[0] ^ fb, fb};
        end
        return c;
    endfunction

endpackage
